// >>> design/presence_pkg.sv
package presence_pkg;
  // timing: one second tick derived from the system clock period
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned TICK_CYC = SEC_NS / CLK_NS;
  localparam int unsigned TW = 9;
  // delays in seconds
  localparam logic [7:0] EXT_CYCLE_S = 8'h09;
  localparam logic [7:0] EXT_ACTIVE_S = 8'h06;
  localparam logic [7:0] BASE_DELAY_S = 8'h0A;
  localparam logic [7:0] ADD_DELAY_RST = 8'h00;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CYCLE = 8'h04;
  localparam logic [7:0] OFF_ACTIVE = 8'h08;
  localparam logic [7:0] OFF_ADD = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // control register layout and reset value
  localparam logic [7:0] CTRL_RST = 8'h30;
  localparam int unsigned CTRL_ROLE_LSB = 0;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_TWL_BIT = 4;
  localparam int unsigned CTRL_EXTDEP_BIT = 5;
  localparam int unsigned CTRL_LOCK_LSB = 6;

  typedef enum logic [1:0] {
    ROLE_SINGLE = 2'b00,
    ROLE_MAIN = 2'b01,
    ROLE_EXT = 2'b10
  } role_t;

  typedef enum logic [1:0] {
    MODE_FULL = 2'b00,
    MODE_SEMI1 = 2'b01,
    MODE_SEMI2 = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    LOCK_NONE = 2'b00,
    LOCK_ON = 2'b01,
    LOCK_OFF = 2'b10
  } lock_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_LOCKED = 2'b10
  } state_t;
endpackage

// >>> design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // sync reset, high
  input wire logic pin_i, // asynchronous pin
  output logic sync_o // synchronised level
);
  logic meta_q;

  // two stages; only the second one is visible outside
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> design/sec_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sec_timer #(
  parameter int unsigned W = 9
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // sync reset, high
  input wire logic tick_i, // one second enable pulse
  input wire logic start_i, // load and run
  input wire logic stop_i, // abort, wins over start
  input wire logic [W-1:0] load_i, // seconds to run
  output logic run_o, // timer running
  output logic expire_o // one cycle at the end
);
  logic [W-1:0] cnt_q;

  // a zero load still runs one tick so expiry is never lost
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      run_o <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (stop_i) begin
        cnt_q <= '0;
        run_o <= 1'b0;
      end else if (start_i) begin
        cnt_q <= (load_i == '0) ? W'(1) : load_i;
        run_o <= 1'b1;
      end else if (run_o && tick_i) begin
        if (cnt_q <= W'(1)) begin
          cnt_q <= '0;
          run_o <= 1'b0;
          expire_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule // sec_timer
`default_nettype wire

// >>> design/presence_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module presence_fsm
  import presence_pkg::*;
#(
  parameter int unsigned TICK_CYC_P = TICK_CYC
) (
  input wire logic clk_i, // 10 MHz system clock
  input wire logic sys_rst_i, // sync reset, high
  input wire logic [7:0] addr_i, // register byte address
  input wire logic [7:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  input wire logic pir_motion_i, // motion sensor pin, async
  input wire logic ext_motion_i, // external motion telegram pulse
  input wire logic manual_on_i, // manual ON telegram pulse
  input wire logic manual_off_i, // manual OFF telegram pulse
  input wire logic disable_i, // disable object level
  input wire logic below_twilight_i, // brightness under twilight
  input wire logic above_switchoff_i, // brightness over switch-off
  input wire logic twl_deact_i, // deactivation from main unit
  output logic act_on_o, // actuator output state
  output logic begin_tlg_o, // begin-of-detection telegram
  output logic end_tlg_o, // end-of-detection telegram
  output logic motion_tlg_o, // extension motion telegram
  output logic twl_deact_o, // deactivation to extensions
  output logic locked_o // block is disabled
);
  localparam int unsigned DW = $clog2(TICK_CYC_P + 1);

  logic [7:0] ctrl_q;
  logic [7:0] cyc_q;
  logic [7:0] actv_q;
  logic [7:0] add_q;
  logic [DW-1:0] div_q;
  logic tick_q;
  logic swoff_q;
  state_t st_q;
  state_t st_d;
  logic pir_s;
  logic dly_run;
  logic dly_exp;
  logic cyc_run;
  logic cyc_exp;
  logic act_d;

  ////////////////////////////////////////////////////////////////////
  // register port
  wire sel_ctrl = (addr_i == OFF_CTRL);
  wire sel_cyc = (addr_i == OFF_CYCLE);
  wire sel_actv = (addr_i == OFF_ACTIVE);
  wire sel_add = (addr_i == OFF_ADD);
  wire sel_stat = (addr_i == OFF_STATUS);
  wire [7:0] status_w = {3'b000, cyc_run, dly_run, act_on_o, st_q};
  // unmapped addresses read as zero
  wire [7:0] rd_mux = sel_ctrl ? ctrl_q :
                      sel_cyc ? cyc_q :
                      sel_actv ? actv_q :
                      sel_add ? add_q :
                      sel_stat ? status_w : 8'h00;

  // configuration writes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RST;
      cyc_q <= EXT_CYCLE_S;
      actv_q <= EXT_ACTIVE_S;
      add_q <= ADD_DELAY_RST;
    end else if (wr_i) begin
      if (sel_ctrl) ctrl_q <= wdata_i;
      if (sel_cyc) cyc_q <= wdata_i;
      if (sel_actv) actv_q <= wdata_i;
      if (sel_add) add_q <= wdata_i;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) rdata_o <= 8'h00;
    else rdata_o <= rd_i ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////
  // one second enable; a shorter parameter speeds simulation
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DW'(TICK_CYC_P - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + DW'(1);
      tick_q <= 1'b0;
    end
  end

  // sensor pin crosses into the clock domain
  pin_sync u_pir (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(pir_motion_i),
    .sync_o(pir_s)
  );

  ////////////////////////////////////////////////////////////////////
  // configuration decode
  wire [1:0] role = ctrl_q[CTRL_ROLE_LSB +: 2];
  wire [1:0] mode = ctrl_q[CTRL_MODE_LSB +: 2];
  wire [1:0] lock_act = ctrl_q[CTRL_LOCK_LSB +: 2];
  wire is_ext = (role == ROLE_EXT);
  wire is_main = (role == ROLE_MAIN);
  wire twl_en = ctrl_q[CTRL_TWL_BIT];
  wire ext_dep = ctrl_q[CTRL_EXTDEP_BIT];

  // brightness gate for new detections
  // twilight off or overridden
  wire bright_ok = !twl_en | below_twilight_i | (is_ext & twl_deact_i);
  wire ext_ok = !is_ext & ext_motion_i;
  wire pir_trig = pir_s & bright_ok;
  wire ext_trig = ext_ok & (bright_ok | !ext_dep);
  wire auto_start = (mode != MODE_SEMI1) & (pir_trig | ext_trig);
  wire start_det = (st_q == ST_IDLE) & !disable_i &
                   (manual_on_i | auto_start);
  wire motion_any = pir_s | ext_ok | manual_on_i;
  wire retrig = (st_q == ST_ACTIVE) & !disable_i & !manual_off_i &
                motion_any & !swoff_q & (mode != MODE_SEMI2);
  wire end_det = (st_q == ST_ACTIVE) & !disable_i &
                 (manual_off_i | dly_exp);
  // extension uses its own active time
  wire [TW-1:0] dly_load = is_ext ? {1'b0, actv_q} :
                           {1'b0, BASE_DELAY_S} + {1'b0, add_q};
  wire dly_start = (start_det | retrig) & (mode != MODE_SEMI2);
  wire dly_stop = end_det | disable_i;
  wire cyc_due = (st_q == ST_ACTIVE) & cyc_exp & !end_det & !disable_i;
  wire cyc_start = is_ext & (start_det | cyc_due);

  // detection delay
  sec_timer #(.W(TW)) u_dly (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick_q),
    .start_i(dly_start),
    .stop_i(dly_stop),
    .load_i(dly_load),
    .run_o(dly_run),
    .expire_o(dly_exp)
  );

  // extension telegram cycle
  sec_timer #(.W(TW)) u_cyc (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick_q),
    .start_i(cyc_start),
    .stop_i(dly_stop),
    .load_i({1'b0, cyc_q}),
    .run_o(cyc_run),
    .expire_o(cyc_exp)
  );

  ////////////////////////////////////////////////////////////////////
  // detection state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (disable_i) st_d = ST_LOCKED;
        else if (start_det) st_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (disable_i) st_d = ST_LOCKED;
        else if (end_det) st_d = ST_IDLE;
      end
      ST_LOCKED: begin
        if (!disable_i) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // actuator state, forced while locked
  always_comb begin
    act_d = act_on_o;
    if (is_ext) act_d = 1'b0;
    else if (st_q == ST_LOCKED || disable_i) begin
      if (!disable_i) act_d = 1'b0;
      else if (lock_act == LOCK_ON) act_d = 1'b1;
      else if (lock_act == LOCK_OFF) act_d = 1'b0;
    // main or single drives the output
    end else if (start_det) act_d = 1'b1;
    else if (end_det) act_d = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= ST_IDLE;
      swoff_q <= 1'b0;
      act_on_o <= 1'b0;
      begin_tlg_o <= 1'b0;
      end_tlg_o <= 1'b0;
      motion_tlg_o <= 1'b0;
      twl_deact_o <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      st_q <= st_d;
      swoff_q <= (st_d == ST_ACTIVE) & !is_ext &
                 (swoff_q | (above_switchoff_i & (st_q == ST_ACTIVE)));
      act_on_o <= act_d;
      begin_tlg_o <= start_det & !is_ext;
      end_tlg_o <= !is_ext & (end_det |
                   ((st_q == ST_LOCKED) & !disable_i & act_on_o));
      // telegram at start and cycle only
      motion_tlg_o <= is_ext & (start_det | cyc_due);
      twl_deact_o <= is_main & act_d;
      locked_o <= (st_d == ST_LOCKED);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_rst_idle;
    @(posedge clk_i) disable iff (1'b0)
    sys_rst_i |=> (st_q == ST_IDLE) && !dly_run && !act_on_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("reset did not give idle");

  property p_ext_no_act;
    is_ext && $past(is_ext) |-> !act_on_o && !begin_tlg_o;
  endproperty
  a_ext_no_act: assert property (p_ext_no_act)
    else $error("extension drove actuator");

  property p_man_on;
    (st_q == ST_IDLE) && manual_on_i && !disable_i && !is_ext
      |=> begin_tlg_o && act_on_o && (st_q == ST_ACTIVE);
  endproperty
  a_man_on: assert property (p_man_on)
    else $error("manual on did not begin detection");

  property p_man_off;
    (st_q == ST_ACTIVE) && manual_off_i && !disable_i && !is_ext
      |=> end_tlg_o && (st_q == ST_IDLE) && !dly_run;
  endproperty
  a_man_off: assert property (p_man_off)
    else $error("manual off did not end detection");

  property p_semi1_wait;
    (mode == MODE_SEMI1) && (st_q == ST_IDLE) && !manual_on_i
      |=> st_q != ST_ACTIVE;
  endproperty
  a_semi1_wait: assert property (p_semi1_wait)
    else $error("motion started semi-automatic detection");

  property p_timeout;
    (st_q == ST_ACTIVE) && dly_exp && !disable_i |=> st_q == ST_IDLE;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("delay expiry did not end detection");

  property p_lock;
    disable_i |=> (st_q == ST_LOCKED) && locked_o;
  endproperty
  a_lock: assert property (p_lock)
    else $error("disable did not lock");

  property p_semi2_nodly;
    (mode == MODE_SEMI2) && $stable(mode) && (st_q == ST_ACTIVE)
      && $past(st_q) == ST_IDLE |-> !dly_run;
  endproperty
  a_semi2_nodly: assert property (p_semi2_nodly)
    else $error("delay ran in semi-automatic II");

  property p_retrig_quiet;
    (st_q == ST_ACTIVE) && !cyc_exp |=> !motion_tlg_o;
  endproperty
  a_retrig_quiet: assert property (p_retrig_quiet)
    else $error("retrigger sent extension telegram");

  property p_cycle_tlg;
    is_ext && (st_q == ST_ACTIVE) && cyc_exp && !dly_exp
      && !manual_off_i && !disable_i |=> motion_tlg_o ##1 cyc_run;
  endproperty
  a_cycle_tlg: assert property (p_cycle_tlg)
    else $error("missing cyclic extension telegram");

  property p_ext_input;
    is_ext && (st_q == ST_IDLE) && !pir_s && !manual_on_i
      |=> st_q != ST_ACTIVE;
  endproperty
  a_ext_input: assert property (p_ext_input)
    else $error("extension took external motion");

  property p_twl_out;
    is_main && $past(is_main) |-> twl_deact_o == act_on_o;
  endproperty
  a_twl_out: assert property (p_twl_out)
    else $error("deactivation does not follow lighting");

  property p_swoff_ext;
    is_ext |=> !swoff_q;
  endproperty
  a_swoff_ext: assert property (p_swoff_ext)
    else $error("switch-off latched in extension");

  c_start: cover property ((st_q == ST_IDLE) ##1 (st_q == ST_ACTIVE));
  c_ext_cycle: cover property (motion_tlg_o && cyc_run);
  c_timeout: cover property (dly_exp ##1 end_tlg_o);
  c_lock: cover property (locked_o ##1 !locked_o);
endmodule // presence_fsm
`default_nettype wire

// >>> sim/peer_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the main unit and a pushbutton sharing the motion group
module peer_bus_model #(
  parameter int unsigned HOLD_P = 100 // main unit delay in clocks
) (
  input wire logic clk_i, // system clock
  input wire logic sys_rst_i, // sync reset, high
  input wire logic send_i, // bench asks for a motion telegram
  input wire logic motion_tlg_i, // motion report from the extension
  output logic ext_motion_o, // one-cycle motion telegram
  output logic twl_deact_o // deactivation level while lit
);
  int unsigned hold_q;
  //////////////////////////////////////////////////////////////////////
  // hold outlasts cycle
  // lamp held for the main delay, refreshed by every report, so a cycle
  // longer than the hold would let the lamp drop mid-presence
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hold_q <= 0;
      ext_motion_o <= 1'b0;
    end else begin
      ext_motion_o <= send_i;
      if (motion_tlg_i) begin
        hold_q <= HOLD_P;
      end else if (hold_q != 0) begin
        hold_q <= hold_q - 1;
      end
    end
  end
  assign twl_deact_o = (hold_q != 0);
endmodule // peer_bus_model
`default_nettype wire

// >>> sim/presence_detect_role_mode_fsm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module presence_detect_role_mode_fsm_tb;
  import presence_pkg::*;
  localparam int unsigned TCK = 10; // clocks per second, shortened
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pir_motion_i = 1'b0;
  logic manual_on_i = 1'b0;
  logic manual_off_i = 1'b0;
  logic disable_i = 1'b0;
  logic below_twilight_i = 1'b1;
  logic above_switchoff_i = 1'b0;
  logic send_i = 1'b0;
  logic [7:0] rdata_o;
  logic ext_motion, twl_in, act_on_o, begin_tlg_o, end_tlg_o;
  logic motion_tlg_o, twl_deact_o, locked_o;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  wire [2:0] outs = {motion_tlg_o, end_tlg_o, begin_tlg_o};

  always #50 clk_i = ~clk_i;

  presence_fsm #(.TICK_CYC_P(TCK)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pir_motion_i(pir_motion_i), .ext_motion_i(ext_motion),
    .manual_on_i(manual_on_i), .manual_off_i(manual_off_i),
    .disable_i(disable_i), .below_twilight_i(below_twilight_i),
    .above_switchoff_i(above_switchoff_i), .twl_deact_i(twl_in),
    .act_on_o(act_on_o), .begin_tlg_o(begin_tlg_o),
    .end_tlg_o(end_tlg_o), .motion_tlg_o(motion_tlg_o),
    .twl_deact_o(twl_deact_o), .locked_o(locked_o));

  peer_bus_model #(.HOLD_P(10 * TCK)) peer (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .send_i(send_i),
    .motion_tlg_i(motion_tlg_o), .ext_motion_o(ext_motion),
    .twl_deact_o(twl_in));

  //////////////////////////////////////////////////////////////////////
  // shared helpers
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask

  // 0 manual on, 1 manual off, 2 motion telegram via the peer
  task pulse(input int s);
    @(posedge clk_i);
    case (s)
      0: manual_on_i <= 1'b1;
      1: manual_off_i <= 1'b1;
      default: send_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {manual_on_i, manual_off_i, send_i} <= 3'b000;
    #1;
  endtask

  // bounded wait for begin, end or motion telegram
  task wt(input int s, input int mx, output int n);
    n = 0;
    while (outs[s] !== 1'b1 && n < mx) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task t_regs;
    rd(OFF_CTRL, CTRL_RST);
    rd(OFF_CYCLE, EXT_CYCLE_S);
    rd(OFF_ACTIVE, EXT_ACTIVE_S);
    rd(OFF_ADD, ADD_DELAY_RST);
    rd(OFF_STATUS, 8'h00);
    rd(8'hFC, 8'h00);
    $display("test regs done");
  endtask

  task t_main;
    wr(OFF_CTRL, 8'h31);
    pulse(0);
    check(begin_tlg_o, 1'b1);
    check(act_on_o, 1'b1);
    check(twl_deact_o, 1'b1);
    rd(OFF_STATUS, 8'h0D);
    pulse(1);
    check(end_tlg_o, 1'b1);
    check(act_on_o, 1'b0);
    rd(OFF_STATUS, 8'h00);
    $display("test main manual done");
  endtask

  task t_auto;
    int n;
    wr(OFF_CTRL, 8'h30);
    pulse(2);
    wt(0, 4, n);
    check(8'(n < 4), 8'h01);
    wt(1, 120, n);
    check(8'(n >= 85 && n <= 105), 8'h01);
    @(posedge clk_i);
    #1 check(act_on_o, 1'b0);
    // bright room mid-detection: later motion must not stretch the delay
    pulse(0);
    check(begin_tlg_o, 1'b1);
    repeat (50) @(posedge clk_i);
    above_switchoff_i <= 1'b1;
    @(posedge clk_i);
    above_switchoff_i <= 1'b0;
    pulse(2);
    wt(1, 80, n);
    check(8'(n < 60), 8'h01);
    $display("test auto timeout done");
  endtask

  task t_bright;
    int n;
    @(posedge clk_i);
    below_twilight_i <= 1'b0;
    pulse(2);
    wt(0, 6, n);
    check(8'(n), 8'h06);
    // external motion set brightness-independent
    wr(OFF_CTRL, 8'h10);
    pulse(2);
    wt(0, 4, n);
    check(8'(n < 4), 8'h01);
    pulse(1);
    check(end_tlg_o, 1'b1);
    wr(OFF_CTRL, 8'h20);
    pulse(2);
    wt(0, 4, n);
    check(8'(n < 4), 8'h01);
    pulse(1);
    check(end_tlg_o, 1'b1);
    @(posedge clk_i);
    below_twilight_i <= 1'b1;
    $display("test brightness done");
  endtask

  task t_semi1;
    int n;
    wr(OFF_CTRL, 8'h34);
    pulse(2);
    wt(0, 6, n);
    check(8'(n), 8'h06);
    pulse(0);
    check(begin_tlg_o, 1'b1);
    pulse(1);
    check(end_tlg_o, 1'b1);
    pulse(2);
    wt(0, 6, n);
    check(8'(n), 8'h06);
    $display("test semi one done");
  endtask

  task t_semi2;
    int n;
    wr(OFF_CTRL, 8'h38);
    pulse(2);
    wt(0, 4, n);
    check(8'(n < 4), 8'h01);
    wt(1, 130, n);
    check(8'(n), 8'd130);
    pulse(1);
    check(end_tlg_o, 1'b1);
    $display("test semi two done");
  endtask

  task t_ext;
    int n;
    wr(OFF_CTRL, 8'h32);
    pulse(2);
    wt(2, 6, n);
    check(8'(n), 8'h06);
    @(posedge clk_i);
    pir_motion_i <= 1'b1;
    wt(2, 8, n);
    check(8'(n < 8), 8'h01);
    check(act_on_o, 1'b0);
    @(posedge clk_i);
    #1 wt(2, 60, n);
    check(8'(n), 8'd60);
    wt(2, 40, n);
    check(8'(n < 40), 8'h01);
    check(act_on_o, 1'b0);
    @(posedge clk_i);
    pir_motion_i <= 1'b0;
    // still active well inside the six seconds, idle after them
    repeat (38) @(posedge clk_i);
    rd(OFF_STATUS, 8'h19);
    repeat (30) @(posedge clk_i);
    rd(OFF_STATUS, 8'h00);
    // dark room, but the peer still holds the lamp on
    @(posedge clk_i);
    below_twilight_i <= 1'b0;
    pir_motion_i <= 1'b1;
    wt(2, 6, n);
    check(8'(n < 6), 8'h01);
    @(posedge clk_i);
    pir_motion_i <= 1'b0;
    below_twilight_i <= 1'b1;
    repeat (70) @(posedge clk_i);
    $display("test extension done");
  endtask

  task t_lock;
    wr(OFF_CTRL, 8'h70);
    disable_i <= 1'b1;
    @(posedge clk_i);
    #1 check(locked_o, 1'b1);
    check(act_on_o, 1'b1);
    pulse(0);
    check(begin_tlg_o, 1'b0);
    @(posedge clk_i);
    disable_i <= 1'b0;
    @(posedge clk_i);
    #1 check(locked_o, 1'b0);
    check(act_on_o, 1'b0);
    check(end_tlg_o, 1'b1);
    $display("test lock done");
  endtask

  //////////////////////////////////////////////////////////////////////
  // hang guard, well above the roughly 700 cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results;
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_main;
    t_auto;
    t_bright;
    t_semi1;
    t_semi2;
    t_ext;
    t_lock;
    results;
  end
endmodule // presence_detect_role_mode_fsm_tb
`default_nettype wire
